/* snclm_pkg.sv */
// Contract
// - Opcode 0x11 decodes as NaN-aware compare
// - Per enabled channel compare, one bit each
// - Non-null destination gets flag in channel LSB
// - Size eight or less updates one flag half
// - NaN second source is true except not-zero
// - Integer operands behave like plain compare
// - Opcode 0x29 decodes as loop-continue
// - Predicated channel pointer gets update offset
// - Continued channels stay off until loop close
// - All enabled channels continue means jump
// - Update offset high half, jump offset low
// - Opcode 0x26 decodes as loop-entry
// - Push loop then continue mask, reload both
// - Every stack push moves sixteen bits
// - Single program flow makes loop-entry a no-op
package snclm_pkg;
  localparam logic [6:0]  OP_CMPN    = 7'h11;  // NaN-aware compare
  localparam logic [6:0]  OP_CONT    = 7'h29;  // Loop-continue
  localparam logic [6:0]  OP_DO      = 7'h26;  // Loop-entry
  localparam logic [3:0]  CM_NONE    = 4'h0;   // Not a defined modifier
  localparam logic [3:0]  CM_Z       = 4'h1;   // Equal
  localparam logic [3:0]  CM_NZ      = 4'h2;   // Not equal
  localparam logic [3:0]  CM_G       = 4'h3;   // Greater
  localparam logic [3:0]  CM_GE      = 4'h4;   // Greater or equal
  localparam logic [3:0]  CM_L       = 4'h5;   // Less
  localparam logic [3:0]  CM_LE      = 4'h6;   // Less or equal
  localparam int          UIP_MSB    = 31;     // Update offset field
  localparam int          UIP_LSB    = 16;
  localparam int          JIP_MSB    = 15;     // Jump offset field
  localparam int          JIP_LSB    = 0;
  localparam int          HALF_CH    = 8;      // Channels per flag half
  localparam logic [2:0]  SZ_HALF    = 3'h3;   // Size code for 8 channels
  localparam logic [15:0] MASK_RST   = 16'hffff; // Masks after reset
  localparam logic [15:0] FLAG_RST   = 16'h0000; // Flag after reset
  localparam logic [31:0] IP_RST     = 32'h0000_0000;
endpackage : snclm_pkg

/* snclm_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module snclm_exec
  import snclm_pkg::*;
#(
  parameter int CH    = 16,  // Channels
  parameter int DEPTH = 16   // Mask stack entries of 16 bits
) (
  input  wire logic            i_clk_sys,     // Core clock
  input  wire logic            i_resetn,      // Sync reset, active low
  input  wire logic            i_valid,       // Instruction issued
  input  wire logic [6:0]      i_opcode,      // Opcode
  input  wire logic [3:0]      i_cmod,        // Conditional modifier
  input  wire logic [2:0]      i_exec_size,   // Log2 of channel count
  input  wire logic            i_second_half_option, // Upper flag half
  input  wire logic            i_pred_en,     // Predication on
  input  wire logic [CH-1:0]   i_predicate_mask,
  input  wire logic [CH-1:0]   i_execution_mask,
  input  wire logic [32*CH-1:0] i_src0,       // Source 0 per channel
  input  wire logic [32*CH-1:0] i_src1,       // Source 1 per channel
  input  wire logic            i_is_float,    // Operands are float
  input  wire logic            i_dst_null,    // Destination is null
  input  wire logic            i_single_program_flow,
  input  wire logic [31:0]     i_ip,          // Current pointer
  input  wire logic [31:0]     i_offsets,     // Update and jump offsets
  input  wire logic            i_loop_close,  // Before loop-closing instr
  output logic [CH-1:0]        o_flag,        // Flag register
  output logic [CH-1:0]        o_dst_bit,     // Per-channel LSB value
  output logic [CH-1:0]        o_dst_wen,     // Channels written
  output logic [32*CH-1:0]     o_per_channel_pointer,
  output logic [CH-1:0]        o_pointer_wen, // Pointers updated
  output logic                 o_jump,        // Jump taken pulse
  output logic [31:0]          o_jump_ip,     // Jump target
  output logic [CH-1:0]        o_loop_mask,   // Loop mask
  output logic [CH-1:0]        o_cont_mask,   // Continue mask
  output logic [$clog2(DEPTH):0] o_stack_level, // Stack entries used
  output logic                 o_stack_err,   // Overflow seen, sticky
  output logic                 o_invalid,     // Bad encoding pulse
  output logic                 o_done         // Instruction retired
);

  // Channels enabled by the execution size
  function automatic logic [CH-1:0] size_mask(input logic [2:0] sz);
    logic [CH-1:0] m;
    m = '0;
    for (int k = 0; k < CH; k++) begin
      m[k] = (k < (1 << sz));
    end
    return m;
  endfunction : size_mask

  // Condition of one channel, NaN aware, integer signed
  function automatic logic cond_nan(input logic [31:0] a, input logic [31:0] b,
                                    input logic f, input logic [3:0] cm);
    logic na, nb, eq, lt, un, r;
    na = f && (a[30:23] == 8'hff) && (a[22:0] != 23'h0);
    nb = f && (b[30:23] == 8'hff) && (b[22:0] != 23'h0);
    un = na | nb;
    if (f) begin
      eq = (a == b) || ((a[30:0] == 31'h0) && (b[30:0] == 31'h0));
      if (a[31] != b[31]) begin
        lt = a[31] && !eq;
      end else if (!a[31]) begin
        lt = a[30:0] < b[30:0];
      end else begin
        lt = a[30:0] > b[30:0];
      end
    end else begin
      eq = (a == b);
      lt = $signed(a) < $signed(b);  // Integers as plain compare
    end
    case (cm)
      CM_Z:    r = eq && !un;
      CM_NZ:   r = !eq || un;
      CM_G:    r = !lt && !eq && !un;
      CM_GE:   r = !lt && !un;
      CM_L:    r = lt && !un;
      CM_LE:   r = (lt || eq) && !un;
      default: r = 1'b0;
    endcase
    // NaN second source forces true on all but not-zero
    if (nb && (cm != CM_NZ)) begin
      r = 1'b1;
    end
    return r;
  endfunction : cond_nan

  // Decoded issue
  logic is_cmpn, is_cont, is_do;
  logic [CH-1:0] channel_write_enable;     // Channel write enable
  logic [CH-1:0] cbits;    // Compare result per channel
  logic [CH-1:0] taken;    // Channels taking the continue
  logic signed [15:0] uoff, joff;

  assign is_cmpn = i_valid && (i_opcode == OP_CMPN);
  assign is_cont = i_valid && (i_opcode == OP_CONT);
  assign is_do   = i_valid && (i_opcode == OP_DO);
  assign uoff    = i_offsets[UIP_MSB:UIP_LSB];
  assign joff    = i_offsets[JIP_MSB:JIP_LSB];
  assign channel_write_enable    = i_execution_mask & size_mask(i_exec_size)
                   & (i_pred_en ? i_predicate_mask : {CH{1'b1}});
  assign taken   = channel_write_enable & i_predicate_mask;

  // Per-channel compare results
  for (genvar g = 0; g < CH; g++) begin : g_cmp
    assign cbits[g] = channel_write_enable[g] &&
      cond_nan(i_src0[32*g +: 32], i_src1[32*g +: 32], i_is_float, i_cmod);
  end

  // Compare outputs
  logic [CH-1:0] flag_ff, nxt_flag, dbit_ff, nxt_dbit, dwen_ff, nxt_dwen;

  // Next flag and destination values
  always_comb begin
    nxt_flag = flag_ff;
    nxt_dbit = dbit_ff;
    nxt_dwen = '0;
    if (is_cmpn) begin
      if (i_exec_size <= SZ_HALF) begin
        // Only one half of the flag moves
        if (i_second_half_option) begin
          nxt_flag[CH-1:HALF_CH] = cbits[HALF_CH-1:0];
        end else begin
          nxt_flag[HALF_CH-1:0] = cbits[HALF_CH-1:0];
        end
      end else begin
        nxt_flag = cbits;
      end
      // Flag bit into channel LSB unless null
      if (!i_dst_null) begin
        nxt_dbit = cbits;
        nxt_dwen = channel_write_enable;
      end
    end
  end

  // Compare registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      flag_ff <= FLAG_RST;
      dbit_ff <= '0;
      dwen_ff <= '0;
    end else begin
      flag_ff <= nxt_flag;
      dbit_ff <= nxt_dbit;
      dwen_ff <= nxt_dwen;
    end
  end

  // Pointer and jump state
  logic [32*CH-1:0] pip_ff, nxt_pip;
  logic [CH-1:0]    pwen_ff, nxt_pwen;
  logic             jmp_ff, nxt_jmp;
  logic [31:0]      jip_ff, nxt_jip;

  // Per-channel pointers and jump from loop-continue
  always_comb begin
    nxt_pip  = pip_ff;
    nxt_pwen = '0;
    nxt_jmp  = 1'b0;
    nxt_jip  = jip_ff;
    if (is_cont) begin
      for (int k = 0; k < CH; k++) begin
        if (channel_write_enable[k]) begin
          nxt_pip[32*k +: 32] = taken[k] ? i_ip + 32'($signed(uoff))
                                         : i_ip + 32'h1;
        end
      end
      nxt_pwen = channel_write_enable;
      // All enabled channels continue
      if ((channel_write_enable != '0) && (taken == channel_write_enable)) begin
        nxt_jmp = 1'b1;
        nxt_jip = i_ip + 32'($signed(joff));
      end
    end
  end

  // Pointer registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      pip_ff  <= '0;
      pwen_ff <= '0;
      jmp_ff  <= 1'b0;
      jip_ff  <= IP_RST;
    end else begin
      pip_ff  <= nxt_pip;
      pwen_ff <= nxt_pwen;
      jmp_ff  <= nxt_jmp;
      jip_ff  <= nxt_jip;
    end
  end

  // Masks and mask stack
  localparam int LW = $clog2(DEPTH) + 1;
  logic [CH-1:0] lm_ff, nxt_lm, cm_ff, nxt_cm;
  logic [15:0]   stk_ff [DEPTH];
  logic [15:0]   nxt_stk [DEPTH];
  logic [LW-1:0] lvl_ff, nxt_lvl;
  logic          err_ff, nxt_err, inv_ff, nxt_inv, done_ff, nxt_done;
  logic          do_bad;

  // Predicated loop-entry is an invalid encoding
  assign do_bad = is_do && i_pred_en;

  // Next mask, stack and status values
  always_comb begin
    nxt_lm   = lm_ff;
    nxt_cm   = cm_ff;
    nxt_stk  = stk_ff;
    nxt_lvl  = lvl_ff;
    nxt_err  = err_ff;
    nxt_done = i_valid;
    nxt_inv  = (i_valid && !is_cmpn && !is_cont && !is_do) || do_bad
               || (is_cmpn && (i_cmod == CM_NONE));
    if (is_cont) begin
      // Continued channels leave the continue mask
      nxt_cm = cm_ff & ~taken;
    end else if (i_loop_close) begin
      nxt_cm = lm_ff;  // Back on before the loop-closing instruction
    end
    // Execution size plays no part here
    if (is_do && !do_bad && !i_single_program_flow) begin
      if (lvl_ff + LW'(2) > LW'(DEPTH)) begin
        nxt_err = 1'b1;  // Overflow: nothing pushed
      end else begin
        // Loop mask first, then continue mask, full width
        nxt_stk[lvl_ff[LW-2:0]]         = 16'(lm_ff);
        nxt_stk[lvl_ff[LW-2:0] + 1'b1]  = 16'(cm_ff);
        nxt_lvl = lvl_ff + LW'(2);
      end
      nxt_lm = i_execution_mask;
      nxt_cm = i_execution_mask;
    end
  end

  // Mask and stack registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      lm_ff   <= CH'(MASK_RST);
      cm_ff   <= CH'(MASK_RST);
      lvl_ff  <= '0;
      err_ff  <= 1'b0;
      inv_ff  <= 1'b0;
      done_ff <= 1'b0;
      for (int k = 0; k < DEPTH; k++) begin
        stk_ff[k] <= '0;
      end
    end else begin
      lm_ff   <= nxt_lm;
      cm_ff   <= nxt_cm;
      lvl_ff  <= nxt_lvl;
      err_ff  <= nxt_err;
      inv_ff  <= nxt_inv;
      done_ff <= nxt_done;
      stk_ff  <= nxt_stk;
    end
  end

  // Output wiring
  assign o_flag                = flag_ff;
  assign o_dst_bit             = dbit_ff;
  assign o_dst_wen             = dwen_ff;
  assign o_per_channel_pointer = pip_ff;
  assign o_pointer_wen         = pwen_ff;
  assign o_jump                = jmp_ff;
  assign o_jump_ip             = jip_ff;
  assign o_loop_mask           = lm_ff;
  assign o_cont_mask           = cm_ff;
  assign o_stack_level         = lvl_ff;
  assign o_stack_err           = err_ff;
  assign o_invalid             = inv_ff;
  assign o_done                = done_ff;

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  chk_cmpn_low_half: assert property (
    is_cmpn && i_exec_size <= SZ_HALF && !i_second_half_option
    |=> o_flag[CH-1:HALF_CH] == $past(flag_ff[CH-1:HALF_CH]))
    else $error("upper flag half moved");
  chk_cmpn_high_half: assert property (
    is_cmpn && i_exec_size <= SZ_HALF && i_second_half_option
    |=> o_flag[HALF_CH-1:0] == $past(flag_ff[HALF_CH-1:0]))
    else $error("lower flag half moved");
  chk_null_dst_quiet: assert property (
    is_cmpn && i_dst_null |=> o_dst_wen == '0)
    else $error("null destination written");
  chk_cmpn_dst_bits: assert property (
    is_cmpn && !i_dst_null && i_exec_size > SZ_HALF |=> o_dst_bit == o_flag)
    else $error("destination bit differs from flag");
  chk_cont_jump_all: assert property (
    is_cont && channel_write_enable != '0 && taken == channel_write_enable
    |=> o_jump && o_jump_ip == $past(i_ip) + 32'($signed($past(joff))))
    else $error("missing continue jump");
  chk_cont_no_jump: assert property (
    is_cont && taken != channel_write_enable |=> !o_jump)
    else $error("spurious continue jump");
  chk_cont_masks_off: assert property (
    is_cont |=> (o_cont_mask & $past(taken)) == '0)
    else $error("continued channel still on");
  chk_do_push_two: assert property (
    is_do && !i_pred_en && !i_single_program_flow && lvl_ff + LW'(2) <= LW'(DEPTH)
    |=> o_stack_level == $past(lvl_ff) + LW'(2) && o_loop_mask == $past(i_execution_mask))
    else $error("loop entry push wrong");
  chk_do_push_order: assert property (
    is_do && !i_pred_en && !i_single_program_flow && lvl_ff + LW'(2) <= LW'(DEPTH)
    |=> stk_ff[$past(lvl_ff[LW-2:0])] == 16'($past(lm_ff))
        && stk_ff[$past(lvl_ff[LW-2:0]) + 1'b1] == 16'($past(cm_ff)))
    else $error("loop entry stack order wrong");
  chk_do_spf_nop: assert property (
    is_do && i_single_program_flow |=> $stable(o_stack_level) && o_done)
    else $error("loop entry not a no-op");
  chk_bad_encoding: assert property (
    is_do && i_pred_en |=> o_invalid ##1 !o_invalid || $past(i_valid))
    else $error("predicated loop entry not flagged");

  cov_cont_jump: cover property (is_cont && taken == channel_write_enable && channel_write_enable != '0);
  cov_do_push: cover property (is_do ##1 is_cont ##1 i_loop_close);
  cov_cmpn_high: cover property (is_cmpn && i_second_half_option);
  cov_stack_err: cover property (is_do && !err_ff ##1 o_stack_err);

endmodule : snclm_exec
`default_nettype wire

/* snclm_supplier.sv */
`timescale 1ns/1ps
`default_nettype none
module snclm_supplier
  import snclm_pkg::*;
(
  input  wire logic    i_clk_sys,   // Core clock
  output logic         o_valid,     // Instruction issued
  output logic [6:0]   o_opcode,    // Opcode
  output logic [3:0]   o_cmod,      // Conditional modifier
  output logic [2:0]   o_exec_size, // Size code
  output logic [511:0] o_src0,      // Source 0, all channels
  output logic [511:0] o_src1       // Source 1, all channels
);
  // Idle stream until the bench asks for an instruction
  initial begin
    o_valid = 1'b0;
    o_opcode = 7'h00;
    o_cmod = 4'h0;
    o_exec_size = 3'h0;
    o_src0 = '0;
    o_src1 = '0;
  end
  // One word held for one edge; no saturation or compression field
  // exists here, so neither is ever set
  task automatic send(input logic [6:0] op, input logic [3:0] cm, input logic [2:0] sz,
                      input logic [31:0] a, input logic [31:0] b);
    o_valid <= 1'b1;
    o_opcode <= op;
    o_cmod <= cm;  // Zero for the compare refusal and for every continue and loop-entry word
    o_exec_size <= sz;
    o_src0 <= {16{a}};
    o_src1 <= {16{b}};  // One operand type per word
    // Loop entries overflow the stack only where a test means it
    @(posedge i_clk_sys);
    o_valid <= 1'b0;
    o_src0 <= ~o_src0;  // Stale operands are scrambled
    o_src1 <= ~o_src1;
  endtask : send
endmodule : snclm_supplier
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import snclm_pkg::*;
  typedef struct packed {
    logic [3:0] cm; logic [2:0] sz; logic sh; logic fp;
    logic [31:0] a; logic [31:0] b; logic [15:0] em; logic [15:0] fl;
  } snclm_row_type;
  typedef struct packed {
    logic sh; logic pe; logic [15:0] pm; logic [15:0] em; logic fp;
    logic dn; logic single_program_flow; logic [31:0] ip; logic [31:0] off; logic lc;
  } snclm_ctx_type;
  logic          clk, rst_n;       // Clock and reset
  snclm_ctx_type c, ctx;           // Pending and driven context
  logic          vld;              // Stream outputs
  logic [6:0]    op;
  logic [3:0]    cm;
  logic [2:0]    sz;
  logic [511:0]  s0, s1, ptr;
  logic [15:0]   flag, dbit, dwen, pwen, lmask, cmask;
  logic          jmp, serr, inv, done;
  logic [31:0]   jip;
  logic [4:0]    lvl;
  int            error_cnt, comparisons, cycles;
  // Compare rows: modifier, size, half, float, src0, src1, exec mask, flag
  snclm_row_type rows [11] = '{
    '{4'h1, 3'h4, 1'b0, 1'b0, 32'h5, 32'h5, 16'hffff, 16'hffff},
    '{4'h2, 3'h3, 1'b0, 1'b0, 32'h5, 32'h5, 16'hffff, 16'hff00},
    '{4'h3, 3'h3, 1'b1, 1'b0, 32'hffffffff, 32'h2, 16'hffff, 16'h0000},
    '{4'h5, 3'h4, 1'b0, 1'b0, 32'hffffffff, 32'h2, 16'h0f0f, 16'h0f0f},
    '{4'h4, 3'h4, 1'b0, 1'b1, 32'h3f800000, 32'h7fc00000, 16'hffff, 16'hffff},
    '{4'h1, 3'h4, 1'b0, 1'b1, 32'h3f800000, 32'h7fc00000, 16'h00ff, 16'h00ff},
    '{4'h3, 3'h4, 1'b0, 1'b1, 32'hc0000000, 32'h3f800000, 16'hffff, 16'h0000},
    '{4'h1, 3'h4, 1'b0, 1'b1, 32'h00000000, 32'h80000000, 16'hffff, 16'hffff},
    '{4'h4, 3'h4, 1'b0, 1'b0, 32'h00000001, 32'h7fc00000, 16'hffff, 16'h0000},
    '{4'h6, 3'h4, 1'b0, 1'b0, 32'hffffffff, 32'h00000002, 16'h00ff, 16'h00ff},
    '{4'h6, 3'h4, 1'b0, 1'b1, 32'hbf800000, 32'h40000000, 16'hffff, 16'hffff}};
  snclm_supplier sup (.i_clk_sys(clk), .o_valid(vld), .o_opcode(op), .o_cmod(cm),
    .o_exec_size(sz), .o_src0(s0), .o_src1(s1));
  snclm_exec dut (.i_clk_sys(clk), .i_resetn(rst_n), .i_valid(vld), .i_opcode(op),
    .i_cmod(cm), .i_exec_size(sz), .i_second_half_option(ctx.sh), .i_pred_en(ctx.pe),
    .i_predicate_mask(ctx.pm), .i_execution_mask(ctx.em), .i_src0(s0), .i_src1(s1),
    .i_is_float(ctx.fp), .i_dst_null(ctx.dn), .i_single_program_flow(ctx.single_program_flow),
    .i_ip(ctx.ip), .i_offsets(ctx.off), .i_loop_close(ctx.lc), .o_flag(flag),
    .o_dst_bit(dbit), .o_dst_wen(dwen), .o_per_channel_pointer(ptr),
    .o_pointer_wen(pwen), .o_jump(jmp), .o_jump_ip(jip), .o_loop_mask(lmask),
    .o_cont_mask(cmask), .o_stack_level(lvl), .o_stack_err(serr), .o_invalid(inv),
    .o_done(done));
  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // Compares and counts
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Issues one instruction with the pending context, settles after answer
  task automatic issue(input logic [6:0] o, input logic [3:0] m, input logic [2:0] z,
                       input logic [31:0] a, input logic [31:0] b);
    @(posedge clk);
    ctx <= c;
    sup.send(o, m, z, a, b);
    #1;
  endtask : issue
  // One-cycle loop close pulse
  task automatic close_loop();
    @(posedge clk);
    ctx.lc <= 1'b1;
    @(posedge clk);
    ctx.lc <= 1'b0;
    #1;
  endtask : close_loop
  // Holds reset low for 8 cycles
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1;
  endtask : do_reset
  // Prints counts and verdict
  task automatic wrap_up();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    rst_n = 1'b0;
    c = '0;
    c.em = 16'hffff;
    ctx = c;
    error_cnt = 0;
    comparisons = 0;
    cycles = 0;
    do_reset();
    chk(flag, FLAG_RST);
    chk(lmask, MASK_RST);
    chk(cmask, MASK_RST);
    chk(lvl, 5'h00);
    chk(ptr[31:0], IP_RST);
    $display("test reset done");
    foreach (rows[i]) begin
      c.sh = rows[i].sh;
      c.fp = rows[i].fp;
      c.em = rows[i].em;
      issue(OP_CMPN, rows[i].cm, rows[i].sz, rows[i].a, rows[i].b);
      chk(flag, rows[i].fl);
      chk(done, 1'b1);
      if (rows[i].sz == 3'h4) begin
        chk(dbit & rows[i].em, rows[i].fl);
        chk(dwen, rows[i].em);
      end
    end
    $display("test compare rows done");
    c.dn = 1'b1;  // Null destination, never an architecture register
    issue(OP_CMPN, CM_NZ, 3'h4, 32'h7, 32'h7);
    chk(flag, 16'h0000);
    chk(dwen, 16'h0000);
    c.dn = 1'b0;
    issue(OP_CMPN, CM_NONE, 3'h4, 32'h5, 32'h5);
    chk(inv, 1'b1);
    chk(flag, 16'h0000);
    issue(7'h10, CM_Z, 3'h4, 32'h5, 32'h5);
    chk(inv, 1'b1);
    $display("test refusals done");
    c.ip = 32'h200;
    c.off = {16'hfffe, 16'h0004};  // Offsets aimed at loop close
    c.pm = 16'h000f;
    issue(OP_CONT, CM_NONE, 3'h4, 32'h0, 32'h0);
    chk(ptr[31:0], 32'h1fe);
    chk(ptr[511:480], 32'h201);
    chk(pwen, 16'hffff);
    chk(jmp, 1'b0);
    chk(cmask, 16'hfff0);
    close_loop();
    chk(cmask, 16'hffff);
    c.pe = 1'b1;
    c.pm = 16'h00ff;
    c.ip = 32'h100;
    c.off = {16'h0010, 16'hfff8};  // Jump target inside a block
    issue(OP_CONT, CM_NONE, 3'h4, 32'h0, 32'h0);
    chk(jmp, 1'b1);
    chk(jip, 32'hf8);
    chk(ptr[31:0], 32'h110);
    chk(ptr[287:256], 32'h201);
    chk(pwen, 16'h00ff);
    chk(cmask, 16'hff00);
    $display("test continue done");
    c.pe = 1'b0;
    c.em = 16'h0f0f;
    issue(OP_DO, CM_NONE, 3'h0, 32'h0, 32'h0);
    chk(lmask, 16'h0f0f);
    chk(cmask, 16'h0f0f);
    chk(lvl, 5'h02);
    c.single_program_flow = 1'b1;
    c.em = 16'h00ff;
    issue(OP_DO, CM_NONE, 3'h4, 32'h0, 32'h0);
    chk(done, 1'b1);
    chk(lvl, 5'h02);
    chk(lmask, 16'h0f0f);
    c.single_program_flow = 1'b0;
    c.pe = 1'b1;
    issue(OP_DO, CM_NONE, 3'h4, 32'h0, 32'h0);
    chk(inv, 1'b1);
    chk(lvl, 5'h02);
    c.pe = 1'b0;
    repeat (7) issue(OP_DO, CM_NONE, 3'h4, 32'h0, 32'h0);
    chk(lvl, 5'h10);
    chk(serr, 1'b0);
    issue(OP_DO, CM_NONE, 3'h4, 32'h0, 32'h0);
    chk(serr, 1'b1);
    chk(lvl, 5'h10);
    $display("test loop entry done");
    do_reset();
    chk(lvl, 5'h00);
    chk(serr, 1'b0);
    chk(lmask, MASK_RST);
    chk(flag, FLAG_RST);
    $display("test second reset done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
